/* File: logic/sat_pkg.sv */
// Purpose: constants and types for the acquisition and trigger control block
// Assumes: one 125 MHz clock, synchronous active-high reset
// Notes: sample and level words are unsigned codes
package sat_pkg;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int AUTO_WAIT_MS = 50;
  localparam longint AUTO_WAIT_PS = longint'(AUTO_WAIT_MS) * 64'd1000000000;
  localparam int AUTO_WAIT_CYC = int'(AUTO_WAIT_PS / CLK_PERIOD_PS);
  localparam int NUM_CH = 2;
  localparam int SMP_W = 8;
  localparam int DEPTH_SEL_W = 3;
  localparam logic [DEPTH_SEL_W-1:0] DEPTH_SEL_MAX = 3'h7;
  localparam int CNT_W = 9;
  localparam int ACC_W = SMP_W + 8;
  localparam int MARKER_DIV = 5;
  typedef enum logic [1:0] {SAT_ACQ_NORMAL, SAT_ACQ_AVERAGE, SAT_ACQ_ACCUM, SAT_ACQ_RSVD} sat_acq_t;
  typedef enum logic [1:0] {SAT_TRG_EDGE, SAT_TRG_PATTERN, SAT_TRG_IMMED, SAT_TRG_ARM} sat_trg_t;
  typedef enum logic [1:0] {SAT_PAT_X, SAT_PAT_H, SAT_PAT_L, SAT_PAT_RSVD} sat_pat_t;
  typedef enum logic [1:0] {SAT_WHEN_ENTER, SAT_WHEN_EXIT, SAT_WHEN_DUR, SAT_WHEN_RSVD} sat_when_t;
endpackage : sat_pkg

/* File: logic/sat_acq_trig.sv */
// Purpose: acquisition mode, averaging, persistence and trigger qualification
// Assumes: inputs synchronous to ref_clk; one sample per channel per clock
// Notes: pattern duration qualification is not implemented
// Functional notes
// RQ1 - average depth only 2 to 256, powers
// RQ2 - new waveform weighted one over N
// RQ3 - flag when averaged count reaches depth
// RQ4 - single run: one acquisition per request
// RQ5 - export latest raw acquisition, not average
// RQ6 - accumulate adds acquisitions without erasing
// RQ7 - clear accumulate on mode, scale, delay, dots-off
// RQ8 - normal/average grid change immediate or at end
// RQ9 - accumulate grid change at end or redraw
// RQ10 - dot connect defaults off, toggles per select
// RQ11 - marker offscreen when delay exceeds 5 scales
// RQ12 - edge, pattern, immediate, arming choice
// RQ13 - analyzer-armed correlated use needs immediate mode
// RQ14 - edge trigger on level crossing, chosen slope
// RQ15 - pattern trigger on entry or exit
// RQ16 - high above level, low below level
// RQ17 - don't-care removes channel from pattern
// RQ18 - pattern terms reset to don't-care
// RQ19 - all don't-care pattern never triggers
// RQ20 - normal mode overwrites stored waveform
// RQ21 - 50 ms timeout gives automatic trigger
// RQ22 - registered comparators, entry/exit by match edges
// RQ23 - clear average state on run start, depth change
`timescale 1ns/1ps
module sat_acq_trig
  import sat_pkg::*;
#(
  parameter int AUTO_WAIT = AUTO_WAIT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire sat_pkg::sat_acq_t acq_mode,
  input wire logic [sat_pkg::DEPTH_SEL_W-1:0] avg_depth_sel,
  input wire logic run_repeat,
  input wire logic run_req,
  input wire logic acq_start,
  input wire logic acq_end,
  input wire logic [sat_pkg::SMP_W-1:0] acq_sample,
  input wire logic [sat_pkg::NUM_CH*sat_pkg::SMP_W-1:0] ch_in,
  input wire logic [sat_pkg::NUM_CH*sat_pkg::SMP_W-1:0] ch_level,
  input wire sat_pkg::sat_trg_t trig_mode,
  input wire logic edge_src,
  input wire logic edge_fall,
  input wire logic auto_trig_en,
  input wire logic arm_in,
  input wire sat_pkg::sat_when_t pat_when,
  input wire logic pat_wr,
  input wire logic [sat_pkg::NUM_CH*2-1:0] pat_terms,
  input wire logic grid_toggle,
  input wire logic dots_toggle,
  input wire logic scale_change,
  input wire logic delay_change,
  input wire logic [15:0] hscale,
  input wire logic [15:0] hdelay,
  output logic run_go,
  output logic trig_out,
  output logic auto_trig_flag,
  output logic avg_met,
  output logic [sat_pkg::CNT_W-1:0] avg_count,
  output logic [sat_pkg::ACC_W-1:0] avg_result,
  output logic [sat_pkg::SMP_W-1:0] export_sample,
  output logic accum_clear,
  output logic grid_on,
  output logic dots_on,
  output logic marker_off,
  output logic depth_valid
);
  // run arming: repetitive or one shot per request
  logic run_pend_q, run_pend_d, run_go_q, run_go_d, busy_q, busy_d;
  logic prev_rep_q, run_start;
  assign run_start = run_repeat & ~prev_rep_q;
  always_comb begin
    run_pend_d = run_pend_q;
    busy_d = busy_q;
    if (run_req) run_pend_d = 1'b1; // [RQ4]
    if (acq_start) busy_d = 1'b1;
    if (acq_end) begin
      busy_d = 1'b0;
      if (!run_repeat) run_pend_d = run_req; // [RQ4]
    end
    run_go_d = run_repeat | run_pend_d; // [RQ4]
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_pend_q <= 1'b0;
      busy_q <= 1'b0;
      run_go_q <= 1'b0;
      prev_rep_q <= 1'b0;
    end else begin
      run_pend_q <= run_pend_d;
      busy_q <= busy_d;
      run_go_q <= run_go_d;
      prev_rep_q <= run_repeat;
    end
  end
  assign run_go = run_go_q;

  // averaging: running mean with 1/N weight, count and met flag
  logic [DEPTH_SEL_W-1:0] depth_prev_q;
  logic [CNT_W-1:0] cnt_q, cnt_d, depth_n;
  logic met_q, met_d;
  logic [ACC_W-1:0] avg_q, avg_d;
  logic [SMP_W-1:0] raw_q, raw_d;
  logic dv_q, dv_d;
  logic signed [ACC_W+1:0] diff;
  logic [3:0] shamt;
  always_comb begin
    shamt = 4'(avg_depth_sel) + 4'h1; // [RQ1] N = 2^(sel+1): 2..256
    depth_n = CNT_W'(1) << shamt;
    dv_d = (avg_depth_sel <= DEPTH_SEL_MAX); // [RQ1]
    cnt_d = cnt_q;
    met_d = met_q;
    avg_d = avg_q;
    raw_d = raw_q;
    diff = '0;
    if (acq_end) begin
      raw_d = acq_sample; // [RQ20] [RQ5]
      if (acq_mode == SAT_ACQ_AVERAGE) begin
        diff = $signed({2'b00, acq_sample, 8'h00}) - $signed({2'b00, avg_q});
        avg_d = ACC_W'(($signed({2'b00, avg_q}) + (diff >>> shamt))); // [RQ2]
        if (cnt_q < depth_n) cnt_d = cnt_q + CNT_W'(1);
        if (cnt_d >= depth_n) met_d = 1'b1; // [RQ3]
      end else begin
        avg_d = {acq_sample, 8'h00}; // [RQ20]
      end
    end
    if (run_start || depth_prev_q != avg_depth_sel) begin
      cnt_d = '0; // [RQ23]
      met_d = 1'b0; // [RQ23]
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= '0;
      met_q <= 1'b0;
      avg_q <= '0;
      raw_q <= '0;
      dv_q <= 1'b0;
      depth_prev_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      met_q <= met_d;
      avg_q <= avg_d;
      raw_q <= raw_d;
      dv_q <= dv_d;
      depth_prev_q <= avg_depth_sel;
    end
  end
  assign avg_count = cnt_q;
  assign avg_met = met_q;
  assign avg_result = avg_q;
  assign export_sample = raw_q; // [RQ5]
  assign depth_valid = dv_q;

  // display: persistence clear, grid deferral, dots, trigger marker
  logic grid_q, grid_d, grid_pend_q, grid_pend_d;
  sat_acq_t mode_q;
  logic dots_q, dots_d, clr_q, clr_d, mk_q, mk_d;
  logic [18:0] lim;
  always_comb begin
    dots_d = dots_toggle ? ~dots_q : dots_q; // [RQ10]
    clr_d = (acq_mode != mode_q) | scale_change | delay_change
          | (dots_toggle & dots_q); // [RQ7]
    grid_pend_d = grid_pend_q ^ grid_toggle;
    grid_d = grid_q;
    if (acq_mode == SAT_ACQ_ACCUM) begin
      if (acq_end || clr_d) begin // [RQ9]
        grid_d = grid_q ^ grid_pend_d;
        grid_pend_d = 1'b0;
      end
    end else if (!busy_q || acq_end) begin // [RQ8]
      grid_d = grid_q ^ grid_pend_d;
      grid_pend_d = 1'b0;
    end
    lim = 19'(hscale) * 19'(MARKER_DIV);
    mk_d = 19'(hdelay) > lim; // [RQ11]
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dots_q <= 1'b0; // [RQ10]
      grid_q <= 1'b1;
      grid_pend_q <= 1'b0;
      clr_q <= 1'b0;
      mode_q <= SAT_ACQ_NORMAL;
      mk_q <= 1'b0;
    end else begin
      dots_q <= dots_d;
      grid_q <= grid_d;
      grid_pend_q <= grid_pend_d;
      clr_q <= clr_d; // [RQ6] only cleared on these events
      mode_q <= acq_mode;
      mk_q <= mk_d;
    end
  end
  assign dots_on = dots_q;
  assign grid_on = grid_q;
  assign accum_clear = clr_q;
  assign marker_off = mk_q;

  // trigger: per-channel comparators, pattern match, edge, timeout
  logic [NUM_CH-1:0] above_q, above_d, used, want;
  logic [NUM_CH*2-1:0] pat_q, pat_d;
  logic match_q, match_d, any_used, edge_hit, pat_hit, trg_d, trg_q;
  logic auto_d, auto_q;
  logic [31:0] to_q, to_d;
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      assign above_d[c] = ch_in[c*SMP_W +: SMP_W] > ch_level[c*SMP_W +: SMP_W]; // [RQ16]
      assign used[c] = sat_pat_t'(pat_q[c*2 +: 2]) != SAT_PAT_X; // [RQ17]
      assign want[c] = sat_pat_t'(pat_q[c*2 +: 2]) == SAT_PAT_H ? above_q[c] : ~above_q[c];
    end
  endgenerate
  always_comb begin
    pat_d = pat_wr ? pat_terms : pat_q;
    any_used = |used;
    match_d = any_used & (&(want | ~used)); // [RQ22] [RQ19]
    edge_hit = edge_fall ? (~above_d[edge_src] & above_q[edge_src])
                         : (above_d[edge_src] & ~above_q[edge_src]); // [RQ14]
    unique case (pat_when)
      SAT_WHEN_ENTER: pat_hit = match_d & ~match_q; // [RQ15]
      SAT_WHEN_EXIT: pat_hit = ~match_d & match_q; // [RQ15]
      default: pat_hit = 1'b0;
    endcase
    trg_d = 1'b0;
    unique case (trig_mode) // [RQ12]
      SAT_TRG_EDGE: trg_d = edge_hit;
      SAT_TRG_PATTERN: trg_d = pat_hit & any_used; // [RQ19]
      SAT_TRG_IMMED: trg_d = run_go_q; // [RQ13]
      SAT_TRG_ARM: trg_d = arm_in;
    endcase
    trg_d = trg_d & run_go_q;
    auto_d = 1'b0;
    to_d = to_q;
    if (!run_go_q || trg_d) to_d = '0;
    else if (auto_trig_en) begin
      if (to_q >= 32'(AUTO_WAIT - 1)) begin
        auto_d = 1'b1; // [RQ21]
        to_d = '0;
      end else to_d = to_q + 32'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pat_q <= '0; // [RQ18]
      above_q <= '0;
      match_q <= 1'b0;
      trg_q <= 1'b0;
      auto_q <= 1'b0;
      to_q <= '0;
    end else begin
      pat_q <= pat_d;
      above_q <= above_d; // [RQ22]
      match_q <= match_d;
      trg_q <= trg_d | auto_d;
      auto_q <= auto_d;
      to_q <= to_d;
    end
  end
  assign trig_out = trg_q;
  assign auto_trig_flag = auto_q;
endmodule : sat_acq_trig

/* File: dv/sat_checker.sv */
// Purpose: port assertions, acquisition and trigger
// Assumes: one clock, sync reset
// Notes: pat_q mirrors the loaded terms
`timescale 1ns/1ps
module sat_checker import sat_pkg::*; (
  input wire logic ref_clk, rst, acq_end, pat_wr, auto_trig_en, grid_toggle, dots_toggle,
  input wire logic scale_change, delay_change, run_go, trig_out, auto_trig_flag, avg_met,
  input wire logic accum_clear, grid_on, dots_on, marker_off,
  input wire logic [7:0] acq_sample, export_sample, input wire logic [3:0] pat_terms,
  input wire logic [15:0] hscale, hdelay, input wire logic [2:0] avg_depth_sel,
  input wire logic [8:0] avg_count, input wire sat_pkg::sat_acq_t acq_mode,
  input wire sat_pkg::sat_trg_t trig_mode
);
  logic [3:0] pat_q;
  // copy of the pattern terms, don't-care after reset
  always_ff @(posedge ref_clk) pat_q <= rst ? 4'h0 : (pat_wr ? pat_terms : pat_q);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_gate; !run_go && !$past(run_go) |-> !trig_out; endproperty
  a_gate: assert property (p_gate) else $error("trigger while stopped");
  property p_allx; trig_mode == SAT_TRG_PATTERN && $stable(trig_mode) && pat_q == 4'h0
    && $stable(pat_q) && !pat_wr && !auto_trig_en |=> !trig_out; endproperty
  a_allx: assert property (p_allx) else $error("empty pattern fired");
  property p_met; avg_met && $stable(avg_depth_sel) |-> avg_count >= (9'h002 << avg_depth_sel);
  endproperty
  a_met: assert property (p_met) else $error("met early");
  property p_exp; acq_end && run_go |=> export_sample == $past(acq_sample); endproperty
  a_exp: assert property (p_exp) else $error("export not raw");
  property p_grid_now; grid_toggle && !run_go && acq_mode == SAT_ACQ_NORMAL && $stable(acq_mode)
    |=> grid_on != $past(grid_on); endproperty
  a_grid_now: assert property (p_grid_now) else $error("grid late");
  property p_grid_wait; grid_toggle && acq_mode == SAT_ACQ_ACCUM && $stable(acq_mode)
    && !accum_clear && !acq_end && !scale_change && !delay_change && !dots_toggle
    |=> $stable(grid_on); endproperty
  a_grid_wait: assert property (p_grid_wait) else $error("grid early");
  property p_clr; acq_mode == SAT_ACQ_ACCUM && (scale_change || delay_change
    || dots_toggle && dots_on) |=> accum_clear; endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_dot_tog; dots_toggle |=> dots_on != $past(dots_on); endproperty
  a_dot_tog: assert property (p_dot_tog) else $error("dots stuck");
  property p_dot_hold; !dots_toggle |=> $stable(dots_on); endproperty
  a_dot_hold: assert property (p_dot_hold) else $error("dots moved");
  property p_mark; 1 |=> marker_off == ($past(hdelay) > 5 * $past(hscale)); endproperty
  a_mark: assert property (p_mark) else $error("marker wrong");
  property p_auto; !auto_trig_en |=> !auto_trig_flag; endproperty
  a_auto: assert property (p_auto) else $error("auto while off");
  cover property (avg_met);
  cover property (trig_out && trig_mode == SAT_TRG_PATTERN);
  cover property (accum_clear);
endmodule : sat_checker
bind sat_acq_trig sat_checker sat_checker_inst (.*);

/* File: dv/sat_probe_model.sv */
// Purpose: probe channels and arming source
// Assumes: level 0x80 on both channels
// Notes: one triangle per sweep
`timescale 1ns/1ps
module sat_probe_model (
  input wire logic ref_clk,
  input wire logic sweep,
  output logic [15:0] ch_in = 16'h4070,
  output logic arm_in = 1'b0
);
  int ph = 0;
  // channel 0 rises 0x70 to 0x90 and falls back, channel 1 stays low
  always @(posedge ref_clk) begin
    ph <= sweep ? ph + 1 : 0;
    ch_in <= #1 {8'h40, 8'(8'h70 + 4 * (ph < 9 ? ph : (ph < 17 ? 16 - ph : 0)))};
    arm_in <= #1 sweep; // arming window follows the sweep
  end
endmodule : sat_probe_model

/* File: dv/tb_top.sv */
// Purpose: self-checking bench, acquisition and trigger
// Assumes: probe model drives the channels
// Notes: short auto wait keeps the run brief
`timescale 1ns/1ps
module tb_top;
  import sat_pkg::*;
  logic ref_clk = 0, rst = 1, run_repeat = 0, run_req = 0, acq_start = 0, acq_end = 0;
  logic edge_src = 0, edge_fall = 0, auto_trig_en = 0, pat_wr = 0, grid_toggle = 0;
  logic dots_toggle = 0, scale_change = 0, delay_change = 0, sweep = 0, arm_in;
  logic run_go, trig_out, auto_trig_flag, avg_met, accum_clear, grid_on, dots_on;
  logic marker_off, depth_valid;
  logic [2:0] avg_depth_sel = 0;
  logic [3:0] pat_terms = 0;
  logic [7:0] acq_sample = 0, export_sample, q[$];
  logic [8:0] avg_count;
  logic [15:0] ch_in, ch_level = 16'h8080, hscale = 0, hdelay = 0, avg_result;
  sat_acq_t acq_mode = SAT_ACQ_NORMAL;
  sat_trg_t trig_mode = SAT_TRG_EDGE;
  sat_when_t pat_when = SAT_WHEN_ENTER;
  int failures = 0, total_checks = 0, cyc = 0, n, k, avg_m = 0;
  sat_acq_trig #(.AUTO_WAIT(20)) sat_acq_trig_inst (.*);
  sat_probe_model sat_probe_model_inst (.*);
  always #4 ref_clk = ~ref_clk;
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(int c = 1);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic pulse(ref logic s);
    s = 1;
    step;
    s = 0;
  endtask : pulse
  task automatic conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  // one acquisition, compared with the queued raw sample
  task automatic acquire(int k, int nn);
    pulse(acq_start);
    step(2);
    acq_sample = 8'($urandom);
    q.push_back(acq_sample);
    // reference mean: new sample weighted 1/N in 8.8 fixed point
    avg_m = acq_mode == SAT_ACQ_AVERAGE
          ? avg_m + ((int'(acq_sample) * 256 - avg_m) >>> (avg_depth_sel + 1))
          : int'(acq_sample) * 256;
    pulse(acq_end);
    chk("export_sample", export_sample, q[$]);
    chk("avg_result", avg_result, 16'(avg_m));
    chk("avg_count", avg_count, k);
    step;
    chk("avg_met", avg_met, k >= nn);
  endtask : acquire
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      conclude;
    end
  end
  initial begin
    void'($urandom(7831));
    step(20);
    rst = 0;
    chk("grid_on", grid_on, 1);
    for (k = 0; k < 4; k++) begin
      pulse(dots_toggle);
      chk("dots_on", dots_on, (k + 1) % 2);
    end
    // marker boundary then random scales
    for (k = 0; k < 20; k++) begin
      hscale = k < 2 ? 16'h0100 : 16'($urandom_range(0, 999));
      hdelay = k < 2 ? 16'(16'h0500 + k) : 16'($urandom_range(0, 5999));
      step(2);
      chk("marker_off", marker_off, hdelay > 5 * hscale);
    end
    // repetitive averaging at three depths
    acq_mode = SAT_ACQ_AVERAGE;
    for (n = 0; n < 3; n++) begin
      avg_depth_sel = 3'(n);
      run_repeat = 0;
      step(2);
      run_repeat = 1;
      step(2);
      chk("depth_valid", depth_valid, 1);
      for (k = 1; k <= (2 << n); k++) acquire(k, 2 << n);
    end
    // single runs, one acquisition each
    run_repeat = 0;
    avg_depth_sel = 3'h1;
    step(2);
    for (k = 1; k <= 4; k++) begin
      pulse(run_req);
      chk("run_go", run_go, 1);
      acquire(k, 4);
      chk("run_go", run_go, 0);
    end
    // grid and persistence clearing
    acq_mode = SAT_ACQ_NORMAL;
    step(3);
    pulse(grid_toggle);
    chk("grid_on", grid_on, 0);
    acq_mode = SAT_ACQ_ACCUM;
    step(3);
    pulse(grid_toggle);
    step(2);
    chk("grid_on", grid_on, 0);
    pulse(scale_change);
    chk("accum_clear", accum_clear, 1);
    step;
    chk("grid_on", grid_on, 1);
    pulse(dots_toggle);
    chk("accum_clear", accum_clear, 0);
    pulse(dots_toggle);
    chk("accum_clear", accum_clear, 1);
    // edge rise, edge fall, enter high, exit high, enter low, all ignored
    acq_mode = SAT_ACQ_NORMAL;
    run_repeat = 1;
    for (k = 0; k < 6; k++) begin
      trig_mode = k < 2 ? SAT_TRG_EDGE : SAT_TRG_PATTERN;
      edge_fall = k == 1;
      pat_when = k == 3 ? SAT_WHEN_EXIT : SAT_WHEN_ENTER;
      pat_terms = 4'(k == 4 ? 2 : (k == 5 ? 0 : 1));
      pulse(pat_wr);
      step(4);
      sweep = 1;
      n = 0;
      repeat (24) begin
        step;
        if (trig_out === 1'b1) n++;
      end
      sweep = 0;
      step(4);
      chk("trig_count", 16'(n), k != 5);
    end
    // automatic trigger with no crossing
    trig_mode = SAT_TRG_EDGE;
    auto_trig_en = 1;
    n = 0;
    repeat (40) begin
      step;
      if (auto_trig_flag === 1'b1) n++;
    end
    chk("auto_trig", 16'(n), 2);
    // arming input and immediate mode
    auto_trig_en = 0;
    trig_mode = SAT_TRG_ARM;
    sweep = 1;
    step(3);
    chk("trig_arm", trig_out, 1);
    sweep = 0;
    step(3);
    chk("trig_arm", trig_out, 0);
    trig_mode = SAT_TRG_IMMED;
    step(2);
    chk("trig_immed", trig_out, 1);
    conclude;
  end
endmodule : tb_top
